// *** hw/ees_defs.svh ***
`ifndef EES_DEFS_SVH
`define EES_DEFS_SVH

// ***************************************************************
// Timing
// ***************************************************************
`define EES_CLK_PERIOD_NS 25
`define EES_GLITCH_NS 100
// Least filter time rounds up to whole cycles
`define EES_GLITCH_CYC ((`EES_GLITCH_NS + `EES_CLK_PERIOD_NS - 1) / `EES_CLK_PERIOD_NS)
`define EES_PU_DELAY_US 1000
`define EES_PU_DELAY_CYC ((`EES_PU_DELAY_US * 1000) / `EES_CLK_PERIOD_NS)
`define EES_WR_CYCLE_US 5000
`define EES_WR_CYCLE_CYC ((`EES_WR_CYCLE_US * 1000) / `EES_CLK_PERIOD_NS)

// ***************************************************************
// Slave address fields
// ***************************************************************
`define EES_ADDR_TYPE_MSB 7
`define EES_ADDR_TYPE_LSB 4
`define EES_ADDR_SEL_MSB 3
`define EES_ADDR_SEL_LSB 1
`define EES_ADDR_RW_BIT 0
`define EES_BITS_PER_BYTE 4'h8

`endif

// *** hw/ees_pkg.sv ***
package ees_pkg;
  typedef enum logic [5:0] {
    EES_IDLE = 6'b000001,
    EES_ADDR = 6'b000010,
    EES_WORD = 6'b000100,
    EES_WDAT = 6'b001000,
    EES_RDAT = 6'b010000,
    EES_SKIP = 6'b100000
  } ees_state_e;
  typedef logic [7:0] ees_byte_t;
endpackage

// *** hw/ees_filter.sv ***
`include "ees_defs.svh"

module ees_filter
  import ees_pkg::*;
#(
  parameter int GLITCH_CYC = `EES_GLITCH_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Pin and clean level
  input wire logic i_pin,
  output logic o_level
);
  logic sync1;
  logic sync2;
  logic sync3;
  logic [7:0] cnt;

  // Three flops; a change counts once the second and third agree
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
    end else begin
      sync1 <= i_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Level must hold past the glitch time before it is believed
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      cnt <= 8'h00;
      o_level <= 1'b1;
    end else if (sync2 != sync3 || sync3 == o_level) begin
      cnt <= 8'h00;
    end else if (cnt >= 8'(GLITCH_CYC)) begin
      o_level <= sync3;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // ees_filter

// *** hw/ees_slave.sv ***
`include "ees_defs.svh"

// Contract
// - Start is data falling while clock high; begins every command.
// - Stop is data rising while clock high; ends every command.
// - Data change during clock high counts as start or stop.
// - Ignore all bus activity until a start is seen.
// - Sample data on clock rise, change output on clock fall.
// - Drive low for zero, release for one; open drain.
// - Slave address top four bits must equal the device-type code.
// - Three select bits match pins or give upper address bits.
// - Last address bit one means read, zero means write.
// - Matching address acknowledged low through the ninth clock.
// - In writes, acknowledge word address and every data byte.
// - In reads, send eight bits then release in ninth clock.
// - Master acknowledge makes device send the next byte.
// - Held in reset below trigger, standby above, both directions.
// - Commands accepted within one millisecond of stable supply.
// - Pulses up to 100 ns on the lines are filtered out.
// - Write protect high inhibits writes; undriven reads low.
// - Undriven chip-select inputs read low for matching.
// - Byte after write address loads the address pointer.
// - During internal write cycle, release data and ignore master.
// - Address during write cycle is not acknowledged, afterwards it is.
// - Write protect sampled before first data byte; high rejects it.
module ees_slave
  import ees_pkg::*;
#(
  parameter logic [3:0] TYPE_CODE = 4'h5, // Arbitrary device-type code
  parameter logic [2:0] PIN_SEL_MASK = 3'h7,
  parameter int PU_DELAY_CYC = `EES_PU_DELAY_CYC,
  parameter int WR_CYCLE_CYC = `EES_WR_CYCLE_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Two-wire bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // Straps
  input wire logic i_chip_select_bit0,
  input wire logic i_chip_select_bit1,
  input wire logic i_chip_select_bit2,
  input wire logic i_write_protect,
  // Memory side
  input wire logic [7:0] i_rd_data,
  output logic [10:0] o_mem_addr,
  output logic [7:0] o_wr_data,
  output logic o_wr_strobe,
  output logic o_rd_strobe,
  output logic o_write_busy,
  output logic o_ready
);
  // ***************************************************************
  // Input conditioning
  // ***************************************************************
  logic scl;
  logic sda;
  logic scl_d;
  logic sda_d;
  logic wp_s1;
  logic wp_s2;
  logic wp_s3;
  logic wp;
  logic [2:0] cs_s1;
  logic [2:0] cs_s2;
  logic [2:0] cs_s3;
  logic [2:0] cs;

  ees_filter #(.GLITCH_CYC(`EES_GLITCH_CYC)) u_scl_filt (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_pin(i_scl),
    .o_level(scl)
  );
  ees_filter #(.GLITCH_CYC(`EES_GLITCH_CYC)) u_sda_filt (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_pin(i_sda),
    .o_level(sda)
  );

  // Straps resync; undriven pins are pulled low at the pad
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wp_s1 <= 1'b0;
      wp_s2 <= 1'b0;
      wp_s3 <= 1'b0;
      wp <= 1'b0;
      cs_s1 <= 3'h0;
      cs_s2 <= 3'h0;
      cs_s3 <= 3'h0;
      cs <= 3'h0;
    end else begin
      wp_s1 <= i_write_protect;
      wp_s2 <= wp_s1;
      wp_s3 <= wp_s2;
      if (wp_s2 == wp_s3) begin
        wp <= wp_s3;
      end
      cs_s1 <= {i_chip_select_bit2, i_chip_select_bit1, i_chip_select_bit0};
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      if (cs_s2 == cs_s3) begin
        cs <= cs_s3;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;
  assign start_det = scl & scl_d & sda_d & ~sda;
  assign stop_det = scl & scl_d & ~sda_d & sda;

  // ***************************************************************
  // Power-up and write cycle timers
  // ***************************************************************
  logic [$clog2(PU_DELAY_CYC + 1)-1:0] pu_cnt;
  logic [$clog2(WR_CYCLE_CYC + 1)-1:0] wr_cnt;
  logic wr_pending;

  // Reset input stands for the supply monitor; it restarts the delay
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      pu_cnt <= '0;
      o_ready <= 1'b0;
    end else if (!o_ready) begin
      if (pu_cnt == ($bits(pu_cnt))'(PU_DELAY_CYC - 1)) begin
        o_ready <= 1'b1;
      end
      pu_cnt <= pu_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wr_cnt <= '0;
      o_write_busy <= 1'b0;
    end else if (stop_det && wr_pending && !o_write_busy) begin
      o_write_busy <= 1'b1;
      wr_cnt <= '0;
    end else if (o_write_busy) begin
      if (wr_cnt == ($bits(wr_cnt))'(WR_CYCLE_CYC - 1)) begin
        o_write_busy <= 1'b0;
      end
      wr_cnt <= wr_cnt + 1'b1;
    end
  end

  // ***************************************************************
  // Byte engine
  // ***************************************************************
  ees_state_e state;
  ees_byte_t shreg;
  ees_byte_t tx;
  logic [3:0] bitcnt;
  logic ack_phase;
  logic read_mode;
  logic wp_latched;
  logic [2:0] upper;
  logic addr_match;
  logic active;

  assign active = o_ready & ~o_write_busy;
  // Selected bits must match pins; others carry upper address
  assign addr_match = (shreg[`EES_ADDR_TYPE_MSB:`EES_ADDR_TYPE_LSB] == TYPE_CODE) &&
    (((shreg[`EES_ADDR_SEL_MSB:`EES_ADDR_SEL_LSB] ^ cs) & PIN_SEL_MASK) == 3'h0);

  // ***************************************************************
  // Write protect strobe
  // ***************************************************************
  logic word_done;
  logic ack_fall;
  logic wp_armed;

  // Engine events, qualified as the engine qualifies them, except that ack_fall does not check the state
  assign word_done = active & ~start_det & ~stop_det & scl_fall & ~ack_phase &
    (bitcnt == `EES_BITS_PER_BYTE) & (state == EES_WORD);
  assign ack_fall = active & ~start_det & ~stop_det & scl_fall & ack_phase;

  // Pin is strobed on the fall that ends the word-byte acknowledge,
  // so a protect change during that acknowledge still counts
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wp_armed <= 1'b0;
      wp_latched <= 1'b0;
    end else if (start_det || stop_det) begin
      wp_armed <= 1'b0;
    end else if (word_done) begin
      wp_armed <= 1'b1;
    end else if (ack_fall && wp_armed) begin
      wp_armed <= 1'b0;
      wp_latched <= wp;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state <= EES_IDLE;
      shreg <= 8'h00;
      tx <= 8'hff;
      bitcnt <= 4'h0;
      ack_phase <= 1'b0;
      read_mode <= 1'b0;
      upper <= 3'h0;
      wr_pending <= 1'b0;
      o_mem_addr <= 11'h000;
      o_wr_data <= 8'h00;
      o_wr_strobe <= 1'b0;
      o_rd_strobe <= 1'b0;
      o_sda_oe <= 1'b0;
      o_sda <= 1'b0;
    end else begin
      o_wr_strobe <= 1'b0;
      o_rd_strobe <= 1'b0;
      o_sda <= 1'b0;
      // Step the page pointer only once the memory has taken the byte
      if (o_wr_strobe) begin
        o_mem_addr <= {o_mem_addr[10:4], o_mem_addr[3:0] + 4'h1};
      end
      if (!active) begin
        state <= EES_IDLE;
        o_sda_oe <= 1'b0;
        tx <= 8'hff;
        bitcnt <= 4'h0;
        ack_phase <= 1'b0;
        if (stop_det) begin
          wr_pending <= 1'b0;
        end
      end else if (start_det) begin
        state <= EES_ADDR;
        bitcnt <= 4'h0;
        ack_phase <= 1'b0;
        o_sda_oe <= 1'b0;
        tx <= 8'hff;
      end else if (stop_det) begin
        state <= EES_IDLE;
        bitcnt <= 4'h0;
        ack_phase <= 1'b0;
        o_sda_oe <= 1'b0;
        tx <= 8'hff;
        // Consumed by the stop that launches the cycle, or it would fire again
        wr_pending <= 1'b0;
      end else begin
        case (state)
          EES_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          EES_ADDR, EES_WORD, EES_WDAT, EES_RDAT: begin
            if (scl_rise) begin
              if (ack_phase) begin
                // Master acknowledge bit in reads
                if (read_mode && sda) begin
                  state <= EES_SKIP;
                end
              end else begin
                shreg <= {shreg[6:0], sda};
                bitcnt <= bitcnt + 4'h1;
              end
            end else if (scl_fall) begin
              if (ack_phase) begin
                ack_phase <= 1'b0;
                bitcnt <= 4'h0;
                o_sda_oe <= 1'b0;
                if (state == EES_RDAT) begin
                  o_sda_oe <= ~i_rd_data[7];
                  tx <= {i_rd_data[6:0], 1'b1};
                  o_rd_strobe <= 1'b1;
                end
              end else if (bitcnt == `EES_BITS_PER_BYTE) begin
                ack_phase <= 1'b1;
                o_sda_oe <= 1'b0;
                case (state)
                  EES_ADDR: begin
                    if (addr_match) begin
                      o_sda_oe <= 1'b1;
                      read_mode <= shreg[`EES_ADDR_RW_BIT];
                      upper <= shreg[`EES_ADDR_SEL_MSB:`EES_ADDR_SEL_LSB] & ~PIN_SEL_MASK;
                      state <= shreg[`EES_ADDR_RW_BIT] ? EES_RDAT : EES_WORD;
                      if (!shreg[`EES_ADDR_RW_BIT]) begin
                        wr_pending <= 1'b0;
                      end
                    end else begin
                      state <= EES_SKIP;
                    end
                  end
                  EES_WORD: begin
                    o_sda_oe <= 1'b1;
                    o_mem_addr <= {upper, shreg};
                    state <= EES_WDAT;
                  end
                  EES_WDAT: begin
                    if (!wp_latched) begin
                      o_sda_oe <= 1'b1;
                      o_wr_data <= shreg;
                      o_wr_strobe <= 1'b1;
                      wr_pending <= 1'b1;
                    end else begin
                      state <= EES_SKIP;
                    end
                  end
                  default: begin
                    o_mem_addr <= o_mem_addr + 11'h001;
                  end
                endcase
              end else if (state == EES_RDAT) begin
                o_sda_oe <= ~tx[7];
                tx <= {tx[6:0], 1'b1};
              end
            end
          end
          EES_SKIP: begin
            o_sda_oe <= 1'b0;
          end
          default: begin
            state <= EES_IDLE;
          end
        endcase
      end
    end
  end
endmodule // ees_slave

// *** tb/ees_mst.sv ***
module ees_mst #(
  parameter int Q = 20
) (
  // Clock and wire
  input wire logic i_clk_sys,
  input wire logic i_sda_wire,
  // Bus drive
  output logic o_scl,
  output logic o_sda_oe,
  // Observed results
  output logic o_res_v,
  output logic [8:0] o_res
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********
  // Master
  // ********
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    o_res_v = 1'b0;
    o_res = 9'h000;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic put(input logic [8:0] v);
    o_res <= v;
    o_res_v <= 1'b1;
    wt(1);
    o_res_v <= 1'b0;
  endtask
  task automatic start();
    wt(Q);
    o_sda_oe <= 1'b0;
    wt(Q);
    o_scl <= 1'b1;
    wt(2 * Q);
    o_sda_oe <= 1'b1;
    wt(2 * Q);
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    wt(Q);
    o_sda_oe <= 1'b1;
    wt(Q);
    o_scl <= 1'b1;
    wt(2 * Q);
    o_sda_oe <= 1'b0;
    wt(4 * Q);
  endtask
  // Data moves mid-low only, so no false start or stop
  task automatic bit1(input logic b, output logic r);
    wt(Q);
    o_sda_oe <= !b;
    wt(Q);
    o_scl <= 1'b1;
    wt(Q);
    r = i_sda_wire;
    wt(Q);
    o_scl <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit1(b[i], r);
    bit1(1'b1, r);
    put({8'h00, r});
  endtask
  task automatic recv(input logic nak);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--) bit1(1'b1, d[i]);
    bit1(nak, r);
    put({1'b0, d});
  endtask
  // Short low pulse while the clock is high
  task automatic glitch();
    wt(Q);
    o_sda_oe <= 1'b1;
    wt(2);
    o_sda_oe <= 1'b0;
    wt(Q);
    o_scl <= 1'b0;
  endtask
endmodule // ees_mst

// *** tb/ees_slave_props.sv ***
module ees_slave_props #(
  parameter int PU_DELAY_CYC = 20,
  parameter int WR_CYCLE_CYC = 50
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_write_protect,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_wr_strobe,
  input wire logic o_write_busy,
  input wire logic o_ready
);
  int rdy_cnt;
  int busy_cnt;
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) rdy_cnt <= 0;
    else if (!o_ready) rdy_cnt <= rdy_cnt + 1;
  end
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) busy_cnt <= 0;
    else if (o_write_busy) busy_cnt <= busy_cnt + 1;
    else busy_cnt <= 0;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  sequence s_clk_high;
    i_scl && $past(i_scl);
  endsequence
  sequence s_busy_run;
    o_write_busy [*8];
  endsequence
  a_ready_gate: assert property (!o_ready |-> !o_sda_oe)
    else $error("drive before ready");
  a_ready_time: assert property ($rose(o_ready) |->
    rdy_cnt >= PU_DELAY_CYC - 2 && rdy_cnt <= PU_DELAY_CYC + 2) else $error("ready time");
  a_ready_holds: assert property (o_ready |=> o_ready)
    else $error("ready dropped");
  a_open_drain: assert property (o_sda == 1'b0)
    else $error("sda drives high");
  a_drive_on_low: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("drive while clock high");
  a_stable_high: assert property (s_clk_high |-> $stable(o_sda_oe))
    else $error("sda moved in high");
  a_busy_quiet: assert property (o_write_busy |-> !o_sda_oe)
    else $error("drive while busy");
  a_busy_min: assert property ($rose(o_write_busy) |-> s_busy_run)
    else $error("busy too short");
  a_busy_max: assert property (busy_cnt <= WR_CYCLE_CYC + 2)
    else $error("busy too long");
  a_wp_block: assert property (o_wr_strobe |-> !i_write_protect)
    else $error("write while protected");
endmodule // ees_slave_props
bind ees_slave ees_slave_props #(
  .PU_DELAY_CYC(PU_DELAY_CYC),
  .WR_CYCLE_CYC(WR_CYCLE_CYC)
) ees_slave_props_inst (
  .i_clk_sys(i_clk_sys),
  .i_reset(i_reset),
  .i_scl(i_scl),
  .i_write_protect(i_write_protect),
  .o_sda(o_sda),
  .o_sda_oe(o_sda_oe),
  .o_wr_strobe(o_wr_strobe),
  .o_write_busy(o_write_busy),
  .o_ready(o_ready)
);

// *** tb/test_i2c_eeprom_slave_interface.sv ***
module test_i2c_eeprom_slave_interface;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] TC = 4'h6; // Arbitrary device-type code
  logic clk, rst, wp, sda_w, m_scl, m_oe, m_v, d_sda, d_oe, wstb, busy, rdy, rstb;
  logic [2:0] cs;
  logic [8:0] m_res;
  logic [10:0] maddr;
  logic [7:0] wdat, rdat, w, d0, d1;
  logic [8:0] exp_res[$];
  logic [18:0] exp_wr[$];
  int n_errors, checked, n_rd;
  // Pull-up on the shared data wire
  assign sda_w = !(m_oe || (d_oe && !d_sda));
  assign rdat = maddr[7:0] ^ 8'h5a;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ees_slave #(.TYPE_CODE(TC), .PIN_SEL_MASK(3'h7), .PU_DELAY_CYC(20),
    .WR_CYCLE_CYC(2000)) ees_slave_inst (
    .i_clk_sys(clk), .i_reset(rst), .i_scl(m_scl), .i_sda(sda_w),
    .o_sda(d_sda), .o_sda_oe(d_oe), .i_chip_select_bit0(cs[0]),
    .i_chip_select_bit1(cs[1]), .i_chip_select_bit2(cs[2]),
    .i_write_protect(wp), .i_rd_data(rdat), .o_mem_addr(maddr),
    .o_wr_data(wdat), .o_wr_strobe(wstb), .o_rd_strobe(rstb),
    .o_write_busy(busy), .o_ready(rdy));
  ees_mst ees_mst_inst (.i_clk_sys(clk), .i_sda_wire(sda_w), .o_scl(m_scl),
    .o_sda_oe(m_oe), .o_res_v(m_v), .o_res(m_res));
  // ********
  // Checking
  // ********
  always @(posedge clk) begin
    if (m_v) begin
      checked++;
      if (exp_res.size() == 0 || m_res !== exp_res[0]) begin
        n_errors++;
        $display("[ERR] %0t bus result %h", $time, m_res);
      end
      if (exp_res.size() != 0) void'(exp_res.pop_front());
    end
    if (wstb) begin
      checked++;
      if (exp_wr.size() == 0 || {maddr, wdat} !== exp_wr[0]) begin
        n_errors++;
        $display("[ERR] %0t write %h at %h", $time, wdat, maddr);
      end
      if (exp_wr.size() != 0) void'(exp_wr.pop_front());
    end
    if (rstb) n_rd++;
  end
  task automatic end_sim();
    if (exp_res.size() + exp_wr.size() != 0) begin
      n_errors++;
      $display("[ERR] %0t results missing", $time);
    end
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic sb(input logic [7:0] b, input logic nak);
    exp_res.push_back({8'h00, nak});
    ees_mst_inst.send(b);
  endtask
  task automatic rb(input logic [7:0] e, input logic nak);
    exp_res.push_back({1'b0, e});
    ees_mst_inst.recv(nak);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 3000 && (!rdy || busy); k++) @(posedge clk);
    if (!rdy || busy) begin
      n_errors++;
      $display("[ERR] %0t wait ran out", $time);
      end_sim();
    end
  endtask
  initial begin
    rst = 1'b1;
    wp = 1'b0;
    cs = 3'h0;
    void'($urandom(50080));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    w = 8'($urandom);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    cs <= 3'($urandom);
    for (int k = 0; k < 100 && !rdy; k++) @(posedge clk);
    wait_idle();
    ees_mst_inst.start();
    sb({TC, cs, 1'b0}, 1'b0);
    sb(w, 1'b0);
    exp_wr.push_back({3'h0, w, d0});
    exp_wr.push_back({3'h0, w[7:4], 4'(w[3:0] + 4'h1), d1});
    sb(d0, 1'b0);
    sb(d1, 1'b0);
    ees_mst_inst.stop();
    ees_mst_inst.start();
    sb({TC, cs, 1'b0}, 1'b1);
    ees_mst_inst.stop();
    wait_idle();
    ees_mst_inst.start();
    sb({TC, cs, 1'b0}, 1'b0);
    sb(w, 1'b0);
    ees_mst_inst.start();
    sb({TC, cs, 1'b1}, 1'b0);
    rb(w ^ 8'h5a, 1'b0);
    rb(8'(w + 8'h01) ^ 8'h5a, 1'b1);
    ees_mst_inst.stop();
    checked++;
    if (n_rd != 2) begin
      n_errors++;
      $display("[ERR] %0t read strobes %0d", $time, n_rd);
    end
    ees_mst_inst.start();
    sb({TC, ~cs, 1'b0}, 1'b1);
    ees_mst_inst.stop();
    ees_mst_inst.start();
    sb({~TC, cs, 1'b0}, 1'b1);
    ees_mst_inst.stop();
    wp <= 1'b1;
    ees_mst_inst.start();
    sb({TC, cs, 1'b0}, 1'b0);
    sb(w, 1'b0);
    sb(d0, 1'b1);
    ees_mst_inst.stop();
    wp <= 1'b0;
    ees_mst_inst.glitch();
    sb({TC, cs, 1'b0}, 1'b1);
    ees_mst_inst.stop();
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule // test_i2c_eeprom_slave_interface
